// ### rtl/isw_pkg.sv
package isw_pkg;
  // register byte offsets
  localparam logic [7:0] ISW_OFF_CTRL    = 8'h00;
  localparam logic [7:0] ISW_OFF_PFLAG_A = 8'h04;
  localparam logic [7:0] ISW_OFF_PFLAG_B = 8'h08;
  localparam logic [7:0] ISW_OFF_PEN_A   = 8'h0c;
  localparam logic [7:0] ISW_OFF_PEN_B   = 8'h10;
  localparam logic [7:0] ISW_OFF_STATUS  = 8'h14;
  localparam logic [7:0] ISW_OFF_ASYNC   = 8'h18;

  // irq_control_reg fields
  localparam int ISW_GIE_BIT  = 7;
  localparam int ISW_PGE_BIT  = 6;
  localparam int ISW_TEN_BIT  = 5;
  localparam int ISW_EEN_BIT  = 4;
  localparam int ISW_CEN_BIT  = 3;
  localparam int ISW_TFL_BIT  = 2;
  localparam int ISW_EFL_BIT  = 1;
  localparam int ISW_CFL_BIT  = 0;

  // status fields
  localparam int ISW_PD_BIT   = 3;
  localparam int ISW_TO_BIT   = 4;
  localparam int ISW_SLP_BIT  = 0;

  // widths: 3 core + 8 + 1 peripheral sources = 12
  localparam int ISW_NSRC     = 12;
  localparam int ISW_PA_W     = 8;
  localparam int ISW_PB_W     = 1;
  localparam int ISW_PORT_W   = 4;
  localparam int ISW_PC_W     = 13;

  // reset values
  localparam logic [7:0] ISW_CTRL_RST  = 8'h00;
  localparam logic       ISW_PD_RST    = 1'b1;
  localparam logic       ISW_TO_RST    = 1'b1;
  localparam logic [ISW_PC_W-1:0] ISW_VECTOR = 13'h0004;

  typedef enum logic [1:0] {
    ISW_RUN,
    ISW_SLEEP,
    ISW_POST_WAKE
  } isw_state_e;
endpackage : isw_pkg

// ### rtl/isw_sync.sv
module isw_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_reg;

  // first stage is read only by the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      q_o      <= '0;
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end
endmodule : isw_sync

// ### rtl/isw_top.sv
// Behaviour
// - twelve sources, each with flag and enable, plus one global enable
// - flags set on their events whatever the enables hold
// - global enable at control bit 7 gates every interrupt
// - global enable with flag and enable both set vectors at once
// - every reset clears the global enable
// - return from interrupt sets the global enable again
// - core flags in control register; peripheral group gated by group enable
// - taking an interrupt clears global enable, loads 0004h
// - pin and port-change response three to four cycles after event
// - power-down clears watchdog, clears pd, sets to, stops oscillator
// - ports hold their drive state during power-down
// - wake on reset, watchdog time-out or enabled interrupts
// - pd set at power-up; to cleared by watchdog wake-up
// - only asynchronous peripherals and the core sources raise flags while powered down
// - wake needs the source enable, not the global enable
// - after wake run prefetched instruction, then vector if enabled
// - enabled pending request makes power-down a no-operation
// - request during power-down completes it, then wakes at once
module isw_top
  import isw_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [31:0]           wb_dat_i,
  input  wire logic [3:0]            wb_sel_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic                  external_irq_pin_i,
  input  wire logic [ISW_PORT_W-1:0] port_change_i,
  input  wire logic                  timer_zero_ovf_i,
  input  wire logic [ISW_PA_W-1:0]   periph_evt_a_i,
  input  wire logic [ISW_PB_W-1:0]   periph_evt_b_i,
  input  wire logic                  core_sleep_i,
  input  wire logic                  core_return_from_irq_instr_i,
  input  wire logic                  core_step_i,
  input  wire logic                  watchdog_en_i,
  input  wire logic                  watchdog_timeout_i,
  output logic                       irq_take_o,
  output logic      [ISW_PC_W-1:0]   irq_vector_o,
  output logic                       watchdog_clear_o,
  output logic                       osc_stop_o,
  output logic                       io_hold_o,
  output logic                       wake_o
);
  logic [7:0]          ctrl_reg;
  logic [ISW_PA_W-1:0] pfa_reg, pea_reg;
  logic [ISW_PB_W-1:0] pfb_reg, peb_reg;
  logic [8:0]          async_reg;
  logic                pd_reg, to_reg;
  isw_state_e          state_reg;
  logic [ISW_PORT_W:0] pin_s, pin_prev_reg;
  logic                wr, acc;
  logic                ext_set, chg_set, pending;
  logic [ISW_PA_W-1:0] pa_set;
  logic [ISW_PB_W-1:0] pb_set;
  logic [7:0]          pfb_upd;
  logic                take, sleep_go, sleep_nop;

  function automatic logic hit(input logic [7:0] off);
    return wb_adr_i == off;
  endfunction : hit

  function automatic logic [7:0] upd(input logic [7:0] cur,
                                     input logic       sel,
                                     input logic [7:0] wd,
                                     input logic [7:0] set);
    return ((sel && wr) ? wd : cur) | set;
  endfunction : upd

  // pins pass two flops before edge detection
  isw_sync #(.W(ISW_PORT_W + 1)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({external_irq_pin_i, port_change_i}),
    .q_o   (pin_s)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) pin_prev_reg <= '0;
    else       pin_prev_reg <= pin_s;
  end

  assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr  = acc && wb_we_i && wb_sel_i[0];
  assign ext_set = pin_s[ISW_PORT_W] && !pin_prev_reg[ISW_PORT_W];
  assign chg_set = pin_s[ISW_PORT_W-1:0] != pin_prev_reg[ISW_PORT_W-1:0];
  // clocked peripherals are frozen while the oscillator is off
  assign pa_set = periph_evt_a_i &
                  ((state_reg == ISW_SLEEP) ? async_reg[7:0]
                                            : '1);
  assign pb_set = periph_evt_b_i &
                  ((state_reg == ISW_SLEEP) ? async_reg[8:8]
                                            : '1);

  // enabled request regardless of global enable
  assign pending = (ctrl_reg[ISW_TEN_BIT] && ctrl_reg[ISW_TFL_BIT]) ||
                   (ctrl_reg[ISW_EEN_BIT] && ctrl_reg[ISW_EFL_BIT]) ||
                   (ctrl_reg[ISW_CEN_BIT] && ctrl_reg[ISW_CFL_BIT]) ||
                   (ctrl_reg[ISW_PGE_BIT] &&
                    (|(pfa_reg & pea_reg) || |(pfb_reg & peb_reg)));
  assign take = (state_reg == ISW_RUN) && ctrl_reg[ISW_GIE_BIT] &&
                pending && !irq_take_o;
  assign sleep_go  = (state_reg == ISW_RUN) && core_sleep_i && !pending;
  assign sleep_nop = (state_reg == ISW_RUN) && core_sleep_i && pending;
  // flag b is one bit wide, so it shares the byte-wide update helper
  assign pfb_upd = upd({7'h00, pfb_reg}, hit(ISW_OFF_PFLAG_B),
                       wb_dat_i[7:0], {7'h00, pb_set});

  // control register: set wins over a software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= ISW_CTRL_RST;
    end else begin
      ctrl_reg <= upd(ctrl_reg, hit(ISW_OFF_CTRL), wb_dat_i[7:0],
                      {5'h00, timer_zero_ovf_i, ext_set, chg_set});
      if (take)
        ctrl_reg[ISW_GIE_BIT] <= 1'b0;
      else if (core_return_from_irq_instr_i)
        ctrl_reg[ISW_GIE_BIT] <= 1'b1;
    end
  end

  // peripheral flags and enables
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pfa_reg   <= '0;
      pfb_reg   <= '0;
      pea_reg   <= '0;
      peb_reg   <= '0;
      async_reg <= '0;
    end else begin
      pfa_reg <= upd(pfa_reg, hit(ISW_OFF_PFLAG_A), wb_dat_i[7:0],
                     pa_set);
      pfb_reg <= pfb_upd[ISW_PB_W-1:0];
      if (wr && hit(ISW_OFF_PEN_A)) pea_reg <= wb_dat_i[7:0];
      if (wr && hit(ISW_OFF_PEN_B)) peb_reg <= wb_dat_i[0:0];
      if (wr && hit(ISW_OFF_ASYNC)) async_reg <= wb_dat_i[8:0];
    end
  end

  // power-down sequencing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ISW_RUN;
      pd_reg    <= ISW_PD_RST;
      to_reg    <= ISW_TO_RST;
    end else begin
      case (state_reg)
        ISW_RUN: begin
          if (sleep_go) begin
            state_reg <= ISW_SLEEP;
            pd_reg    <= 1'b0;
            to_reg    <= 1'b1;
          end
        end
        ISW_SLEEP: begin
          if (pending) begin
            state_reg <= ISW_POST_WAKE;
          end else if (watchdog_en_i && watchdog_timeout_i) begin
            state_reg <= ISW_POST_WAKE;
            to_reg    <= 1'b0;
          end
        end
        ISW_POST_WAKE: begin
          // prefetched instruction must retire before vectoring
          if (core_step_i) state_reg <= ISW_RUN;
        end
        default: state_reg <= ISW_RUN;
      endcase
    end
  end

  // core-facing outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_take_o       <= 1'b0;
      irq_vector_o     <= ISW_VECTOR;
      watchdog_clear_o <= 1'b0;
      osc_stop_o       <= 1'b0;
      io_hold_o        <= 1'b0;
      wake_o           <= 1'b0;
    end else begin
      irq_take_o       <= take;
      irq_vector_o     <= ISW_VECTOR;
      watchdog_clear_o <= sleep_go;
      osc_stop_o       <= (state_reg == ISW_SLEEP) ? !wake_cond()
                                                   : sleep_go;
      io_hold_o        <= (state_reg == ISW_SLEEP) ? !wake_cond()
                                                   : sleep_go;
      wake_o           <= (state_reg == ISW_SLEEP) && wake_cond();
    end
  end

  function automatic logic wake_cond();
    return pending || (watchdog_en_i && watchdog_timeout_i);
  endfunction : wake_cond

  // wishbone classic slave, one wait state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= acc;
      if (acc && !wb_we_i) begin
        if (hit(ISW_OFF_CTRL))         wb_dat_o <= {24'h0, ctrl_reg};
        else if (hit(ISW_OFF_PFLAG_A)) wb_dat_o <= {24'h0, pfa_reg};
        else if (hit(ISW_OFF_PFLAG_B)) wb_dat_o <= {31'h0, pfb_reg};
        else if (hit(ISW_OFF_PEN_A))   wb_dat_o <= {24'h0, pea_reg};
        else if (hit(ISW_OFF_PEN_B))   wb_dat_o <= {31'h0, peb_reg};
        else if (hit(ISW_OFF_STATUS))
          wb_dat_o <= {27'h0, to_reg, pd_reg, 2'h0,
                       state_reg == ISW_SLEEP};
        else if (hit(ISW_OFF_ASYNC))   wb_dat_o <= {23'h0, async_reg};
        else                           wb_dat_o <= '0;
      end
    end
  end

  a_reset_gie_clear: assert property (
    @(posedge clk_i) rst_i |=> !ctrl_reg[ISW_GIE_BIT])
    else $error("global enable not cleared by reset");

  a_take_needs_gie: assert property (
    @(posedge clk_i) disable iff (rst_i)
    irq_take_o |-> $past(ctrl_reg[ISW_GIE_BIT]) && $past(pending))
    else $error("vector taken without enable and request");

  a_take_clears_gie: assert property (
    @(posedge clk_i) disable iff (rst_i)
    irq_take_o |-> !ctrl_reg[ISW_GIE_BIT] &&
                   irq_vector_o == ISW_VECTOR)
    else $error("take did not clear enable or load vector");

  a_take_at_once: assert property (
    @(posedge clk_i) disable iff (rst_i)
    take |=> irq_take_o)
    else $error("enabled request not vectored");

  a_return_from_irq_instr_sets_gie: assert property (
    @(posedge clk_i) disable iff (rst_i)
    core_return_from_irq_instr_i && !take |=> ctrl_reg[ISW_GIE_BIT])
    else $error("return did not set global enable");

  a_timer_flag_sticky: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ctrl_reg[ISW_TFL_BIT] && !(wr && hit(ISW_OFF_CTRL))
    |=> ctrl_reg[ISW_TFL_BIT])
    else $error("flag cleared without software");

  a_ext_latency: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $rose(external_irq_pin_i) |-> ##[1:3] ctrl_reg[ISW_EFL_BIT])
    else $error("pin flag late");

  a_sleep_entry_fx: assert property (
    @(posedge clk_i) disable iff (rst_i)
    sleep_go |=> !pd_reg && to_reg && osc_stop_o && watchdog_clear_o)
    else $error("power-down entry effects missing");

  a_sleep_nop_keep: assert property (
    @(posedge clk_i) disable iff (rst_i)
    sleep_nop |=> $stable(pd_reg) && $stable(to_reg) &&
                  !watchdog_clear_o && !osc_stop_o)
    else $error("power-down not a no-operation");

  a_wake_on_pending: assert property (
    @(posedge clk_i) disable iff (rst_i)
    state_reg == ISW_SLEEP && pending |=> wake_o && !osc_stop_o)
    else $error("enabled request did not wake");

  a_wdt_wake_to: assert property (
    @(posedge clk_i) disable iff (rst_i)
    state_reg == ISW_SLEEP && !pending && watchdog_en_i &&
    watchdog_timeout_i |=> !to_reg && wake_o)
    else $error("watchdog wake did not clear time-out bit");
endmodule : isw_top

// ### bench/isw_core_model.sv
module isw_core_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic wake_i,
  input  wire logic slow_i,
  input  wire logic sleep_req_i,
  input  wire logic return_from_irq_instr_req_i,
  output logic      core_sleep_o,
  output logic      core_return_from_irq_instr_o,
  output logic      core_step_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] step_cnt_reg;
  logic       armed_reg;
  always_ff @(posedge clk_i) begin
    core_sleep_o  <= !rst_i && sleep_req_i;
    core_return_from_irq_instr_o <= !rst_i && return_from_irq_instr_req_i;
  end
  // slow mode stretches the prefetched instruction so takes must wait
  always_ff @(posedge clk_i) begin
    core_step_o <= 1'b0;
    if (rst_i) begin
      armed_reg    <= 1'b0;
      step_cnt_reg <= 3'h0;
    end else if (wake_i) begin
      armed_reg    <= 1'b1;
      step_cnt_reg <= slow_i ? 3'h4 : 3'h0;
    end else if (armed_reg) begin
      if (step_cnt_reg == 3'h0) begin
        core_step_o <= 1'b1;
        armed_reg   <= 1'b0;
      end else begin
        step_cnt_reg <= step_cnt_reg - 3'h1;
      end
    end
  end
endmodule : isw_core_model

// ### bench/tb_isw_top.sv
module tb_isw_top
  import isw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, cyc, stb, we, pin, tmr, pb, wd_en, wd_to, slp, ret, slow;
  logic [7:0] adr, pa;
  logic [31:0] dat, rdat, q;
  logic [3:0] sel, pchg;
  logic ack, take, wdc, osc, hold, wake, c_slp, c_ret, c_step;
  logic [ISW_PC_W-1:0] vec;
  int n_mismatch, num_checks, n_take, n_wake, n_wdc, n, k;
  isw_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
    .wb_dat_o(rdat), .wb_ack_o(ack), .external_irq_pin_i(pin),
    .port_change_i(pchg), .timer_zero_ovf_i(tmr), .periph_evt_a_i(pa),
    .periph_evt_b_i(pb), .core_sleep_i(c_slp), .core_return_from_irq_instr_i(c_ret),
    .core_step_i(c_step), .watchdog_en_i(wd_en), .watchdog_timeout_i(wd_to),
    .irq_take_o(take), .irq_vector_o(vec), .watchdog_clear_o(wdc),
    .osc_stop_o(osc), .io_hold_o(hold), .wake_o(wake));
  isw_core_model core (.clk_i(clk_i), .rst_i(rst_i), .wake_i(wake),
    .slow_i(slow), .sleep_req_i(slp), .return_from_irq_instr_req_i(ret),
    .core_sleep_o(c_slp), .core_return_from_irq_instr_o(c_ret), .core_step_o(c_step));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    n_take += (take === 1'b1);
    n_wake += (wake === 1'b1);
    n_wdc  += (wdc === 1'b1);
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'hf};
    // hold the request until ack is seen; only the watchdog ends a hang
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    {cyc, stb} <= 2'b00;
  endtask : xfer
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd
  task pulse(input int s);
    @(posedge clk_i);
    case (s)
      0: tmr <= 1'b1;
      1: slp <= 1'b1;
      2: ret <= 1'b1;
      3: wd_to <= 1'b1;
      4: pa <= 8'h08;
      default: pb <= 1'b1;
    endcase
    @(posedge clk_i);
    {tmr, slp, ret, wd_to, pa, pb} <= '0;
  endtask : pulse
  task automatic wait_cnt(ref int c, input int v);
    for (int i = 0; i < 40 && c < v; i++) @(posedge clk_i);
    chk(c, v);
  endtask : wait_cnt
  task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    #200000;
    n_mismatch++;
    tally_and_finish;
  end
  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, adr, dat, sel, pin, pchg, tmr, pa, pb} = '0;
    {slp, ret, slow, wd_en, wd_to} = '0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ISW_OFF_CTRL, 32'h00);
    rd(ISW_OFF_STATUS, 32'h18);
    rd(8'h1c, 32'h00);
    pulse(0);
    rd(ISW_OFF_CTRL, 32'h04);
    chk(n_take, 0);
    wr(ISW_OFF_CTRL, 32'ha4);
    wait_cnt(n_take, 1);
    chk(vec, 32'h4);
    rd(ISW_OFF_CTRL, 32'h24);
    wr(ISW_OFF_CTRL, 32'h20);
    pulse(2);
    rd(ISW_OFF_CTRL, 32'ha0);
    wr(ISW_OFF_CTRL, 32'h00);
    pulse(4);
    wr(ISW_OFF_PEN_A, 32'h08);
    rd(ISW_OFF_PFLAG_A, 32'h08);
    chk(n_take, 1);
    wr(ISW_OFF_CTRL, 32'hc0);
    wait_cnt(n_take, 2);
    rd(ISW_OFF_PFLAG_A, 32'h08);
    wr(ISW_OFF_PFLAG_A, 32'h00);
    pulse(5);
    rd(ISW_OFF_PFLAG_B, 32'h01);
    wr(ISW_OFF_PFLAG_B, 32'h00);
    for (k = 0; k < 2; k++) begin
      wr(ISW_OFF_CTRL, k ? 32'h88 : 32'h90);
      @(posedge clk_i);
      {pin, pchg} <= k ? 5'h01 : 5'h10;
      for (n = 1; n < 8; n++) begin
        @(posedge clk_i);
        #1;
        if (take === 1'b1) break;
      end
      chk(n >= 3 && n <= 4, 1);
      @(posedge clk_i);
      {pin, pchg} <= 5'h00;
      repeat (6) @(posedge clk_i);
      wr(ISW_OFF_CTRL, 32'h00);
    end
    wr(ISW_OFF_CTRL, 32'h20);
    pulse(1);
    repeat (3) @(posedge clk_i);
    chk({osc, hold}, 2'b11);
    chk(n_wdc, 1);
    rd(ISW_OFF_STATUS, 32'h11);
    pulse(0);
    wait_cnt(n_wake, 1);
    repeat (8) @(posedge clk_i);
    chk({osc, hold, n_take[2:0]}, 5'h04);
    rd(ISW_OFF_STATUS, 32'h10);
    pulse(1);
    repeat (4) @(posedge clk_i);
    chk({osc, n_wdc[2:0]}, 4'h1);
    rd(ISW_OFF_STATUS, 32'h10);
    wr(ISW_OFF_CTRL, 32'h20);
    wd_en <= 1'b1;
    pulse(1);
    repeat (3) @(posedge clk_i);
    pulse(3);
    wait_cnt(n_wake, 2);
    rd(ISW_OFF_STATUS, 32'h00);
    slow <= 1'b1;
    wr(ISW_OFF_CTRL, 32'ha0);
    pulse(1);
    repeat (3) @(posedge clk_i);
    pulse(0);
    wait_cnt(n_wake, 3);
    chk(n_take, 4);
    wait_cnt(n_take, 5);
    wr(ISW_OFF_CTRL, 32'h20);
    rd(ISW_OFF_CTRL, 32'h20);
    @(posedge clk_i);
    slp <= 1'b1;
    @(posedge clk_i);
    {slp, tmr} <= 2'b01;
    @(posedge clk_i);
    tmr <= 1'b0;
    wait_cnt(n_wake, 4);
    chk(n_wdc, 4);
    rd(ISW_OFF_STATUS, 32'h10);
    // clocked peripheral events and a disabled watchdog must not wake
    wd_en <= 1'b0;
    wr(ISW_OFF_CTRL, 32'h40);
    pulse(1);
    repeat (3) @(posedge clk_i);
    pulse(4);
    pulse(3);
    repeat (4) @(posedge clk_i);
    chk({osc, n_wake[2:0]}, 4'hc);
    rd(ISW_OFF_PFLAG_A, 32'h00);
    wr(ISW_OFF_ASYNC, 32'h08);
    pulse(4);
    wait_cnt(n_wake, 5);
    rd(ISW_OFF_PFLAG_A, 32'h08);
    tally_and_finish;
  end
endmodule : tb_isw_top
